/* pkg/uls_pkg.sv */
// shared constants and types of the uart line status block
`default_nettype none

package uls_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFF_LSR  = 8'h00;  // line_status, read only
    localparam logic [7:0] OFF_CTRL = 8'h04;  // control, bit 0 queue mode
    localparam logic [7:0] OFF_TXD  = 8'h08;  // write a transmit character
    localparam logic [7:0] OFF_RXD  = 8'h0C;  // read the head receive character
    localparam logic [7:0] OFF_IST  = 8'h10;  // interrupt status, write one to clear
    localparam logic [7:0] OFF_IMSK = 8'h14;  // interrupt mask, same layout

    // line_status bit positions
    localparam int unsigned LSR_FERR = 7;     // error somewhere in the receive queue
    localparam int unsigned LSR_TEMT = 6;     // holding and shift register empty
    localparam int unsigned LSR_THRE = 5;     // holding register or queue empty
    localparam int unsigned LSR_BRK  = 4;     // break at head
    localparam int unsigned LSR_FE   = 3;     // framing error at head
    localparam int unsigned LSR_PE   = 2;     // parity error at head
    localparam int unsigned LSR_OE   = 1;     // overrun
    localparam int unsigned LSR_DR   = 0;     // receive data ready

    // control bit positions
    localparam int unsigned CTRL_FIFO = 0;    // 1 selects queue mode

    // interrupt status and mask bit positions
    localparam int unsigned IRQ_W    = 3;
    localparam int unsigned IRQ_THRE = 0;     // holding register became empty
    localparam int unsigned IRQ_LINE = 1;     // error, break or overrun received
    localparam int unsigned IRQ_RX   = 2;     // a character was received

    // values after reset
    localparam logic             CTRL_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IST_RST  = 3'h0;
    localparam logic [IRQ_W-1:0] IMSK_RST = 3'h0;
    localparam logic             THRE_RST = 1'b1;
    localparam logic             TEMT_RST = 1'b1;

    // one receive queue entry: error tags travel with the character
    typedef struct packed {
        logic       brk;    // break character
        logic       fe;     // framing error
        logic       pe;     // parity error
        logic [7:0] data;   // character
    } uls_rx_entry_t;

endpackage

`default_nettype wire

/* logic/uls_line_status.sv */
// line status flags, receive and transmit queues and apb registers for one uart channel
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - queue mode: bit 7 set when tagged character enters queue
// - reading line_status clears bit 7
// - non-queue mode: bit 6 when holding and shifter empty
// - queue mode: bit 6 when queue and shifter empty
// - non-queue: bit 5 sets on transfer, clears on write
// - queue mode: bit 5 set while queue empty
// - bit 5 raises interrupt when enabled
// - bit 4 after line low one frame
// - one break character per break condition
// - bit 3 on missing stop bit
// - bit 3 follows the head character
// - bit 2 parity error of head character
// - bit 0 while any character is held
module uls_line_status #(
    parameter int unsigned DEPTH        = 16,    // queue depth, power of two
    parameter int unsigned FRAME_CYCLES = 1600   // cycles of low line that make one frame
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    // receiver, same clock
    input  wire logic                  rx_valid,
    input  wire uls_pkg::uls_rx_entry_t rx_entry,
    // serial receive pin
    input  wire logic                  rxd,
    // transmit shifter, same clock
    output var  logic                  tx_valid,
    output var  logic [7:0]            tx_data,
    input  wire logic                  tx_take,
    input  wire logic                  tsr_empty,
    // interrupt
    output var  logic                  irq
);

    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = AW + 1;

    // advance a queue pointer
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return AW'(p + 1'b1);
    endfunction

    // true when a character carries any error tag
    function automatic logic has_tag(input uls_pkg::uls_rx_entry_t e);
        return e.brk | e.fe | e.pe;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb access decode

    logic        acc;        // access completes at this edge
    logic        wr_acc;     // write completes
    logic        rd_acc;     // read completes
    logic        mapped;     // address decodes
    logic [31:0] rd_val;     // read data for current address
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;

    assign acc    = psel & penable & pready_q;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign mapped = (paddr == uls_pkg::OFF_LSR)  || (paddr == uls_pkg::OFF_CTRL)
                 || (paddr == uls_pkg::OFF_TXD)  || (paddr == uls_pkg::OFF_RXD)
                 || (paddr == uls_pkg::OFF_IST)  || (paddr == uls_pkg::OFF_IMSK);

    logic lsr_rd;       // line_status read completes
    logic rxd_rd;       // receive character read completes
    logic txd_wr;       // transmit character write completes
    assign lsr_rd = rd_acc & (paddr == uls_pkg::OFF_LSR);
    assign rxd_rd = rd_acc & (paddr == uls_pkg::OFF_RXD);
    assign txd_wr = wr_acc & (paddr == uls_pkg::OFF_TXD);

    ////////////////////////////////////////////////////////////////////////////
    // control and interrupt registers

    localparam int unsigned IRQ_W = uls_pkg::IRQ_W;
    logic             fifo_q, fifo_d;       // queue mode
    logic [IRQ_W-1:0] ist_q, ist_d;         // sticky events
    logic [IRQ_W-1:0] imsk_q, imsk_d;       // event enables
    logic             irq_q, irq_d;
    logic [IRQ_W-1:0] ev;                   // events this cycle
    logic             mode_chg;             // queue mode toggles, both queues flush

    assign mode_chg = wr_acc & (paddr == uls_pkg::OFF_CTRL)
                    & (pwdata[uls_pkg::CTRL_FIFO] != fifo_q);

    // next control, status and mask; a new event wins over its clear
    always_comb begin
        fifo_d = fifo_q;
        imsk_d = imsk_q;
        ist_d  = ist_q | ev;
        if (wr_acc && paddr == uls_pkg::OFF_CTRL) begin
            fifo_d = pwdata[uls_pkg::CTRL_FIFO];
        end
        if (wr_acc && paddr == uls_pkg::OFF_IMSK) begin
            imsk_d = pwdata[IRQ_W-1:0];
        end
        if (wr_acc && paddr == uls_pkg::OFF_IST) begin
            ist_d = (ist_q & ~pwdata[IRQ_W-1:0]) | ev;
        end
        irq_d = |(ist_d & imsk_d);
    end

    ////////////////////////////////////////////////////////////////////////////
    // break detection on the synchronised receive line

    logic        rxd_s1_q, rxd_s2_q;     // two-stage synchroniser
    logic [31:0] brk_cnt_q, brk_cnt_d;   // low cycles so far
    logic        brk_done_q, brk_done_d; // break already queued for this low period
    logic        brk_push;               // queue one break character now

    // count low time, fire once, rearm when the line returns high
    always_comb begin
        brk_cnt_d  = brk_cnt_q;
        brk_done_d = brk_done_q;
        brk_push   = 1'b0;
        if (rxd_s2_q) begin
            brk_cnt_d  = 32'h0;
            brk_done_d = 1'b0;
        end else if (!brk_done_q) begin
            if (brk_cnt_q == 32'(FRAME_CYCLES - 1)) begin
                brk_push   = 1'b1;
                brk_done_d = 1'b1;
            end else begin
                brk_cnt_d = brk_cnt_q + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive queue with tags; depth one outside queue mode

    uls_pkg::uls_rx_entry_t rmem [DEPTH];  // characters and tags
    uls_pkg::uls_rx_entry_t push_ent;      // entry offered now
    uls_pkg::uls_rx_entry_t head;          // entry at the head
    logic [AW-1:0] rrd_q, rrd_d, rwr_q, rwr_d;
    logic [CW-1:0] rcnt_q, rcnt_d;         // characters held
    logic [CW-1:0] ecnt_q, ecnt_d;         // tagged characters held
    logic [CW-1:0] cap;                    // capacity in this mode
    logic          push_req, push_ok, pop;
    logic          oe_q, oe_d;             // overrun
    logic          ferr_q, ferr_d;         // error summary

    assign cap      = fifo_q ? CW'(DEPTH) : CW'(1);
    assign push_ent = brk_push ? uls_pkg::uls_rx_entry_t'{brk: 1'b1, fe: 1'b0, pe: 1'b0,
                                                          data: 8'h00} : rx_entry;
    assign push_req = brk_push | rx_valid;
    assign push_ok  = push_req & (rcnt_q < cap);
    assign pop      = rxd_rd & (rcnt_q != '0);
    assign head     = rmem[rrd_q];

    // pointers, counts, overrun and error summary
    always_comb begin
        rrd_d  = pop     ? ptr_inc(rrd_q) : rrd_q;
        rwr_d  = push_ok ? ptr_inc(rwr_q) : rwr_q;
        rcnt_d = CW'(rcnt_q + CW'(push_ok) - CW'(pop));
        ecnt_d = CW'(ecnt_q + CW'(push_ok && has_tag(push_ent))
                            - CW'(pop && has_tag(head)));
        oe_d   = (oe_q & ~lsr_rd) | (push_req & ~push_ok);
        // cleared by the read, kept while tagged characters remain, set wins
        ferr_d = (ferr_q & ~lsr_rd & (ecnt_d != '0))
               | (fifo_q & push_ok & has_tag(push_ent));
        if (mode_chg) begin
            rrd_d  = '0;
            rwr_d  = '0;
            rcnt_d = '0;
            ecnt_d = '0;
            ferr_d = 1'b0;
        end
    end

    // storage needs no reset; only written slots are ever read
    always_ff @(posedge pclk) begin
        if (push_ok) begin
            rmem[rwr_q] <= push_ent;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit queue; depth one is the holding register

    logic [7:0]    tmem [DEPTH];    // transmit characters
    logic [AW-1:0] trd_q, trd_d, twr_q, twr_d;
    logic [CW-1:0] tcnt_q, tcnt_d;
    logic          tpush, tpop;
    logic          txv_q, txv_d;    // character offered to shifter
    logic [7:0]    txd_q, txd_d;    // offered character
    logic          thre_q, thre_d;  // holding empty
    logic          temt_q, temt_d;  // holding and shifter empty

    assign tpush = txd_wr & (tcnt_q < cap);
    assign tpop  = tx_take & txv_q;

    // pointers, count, offered head and the two empty flags
    always_comb begin
        trd_d  = tpop  ? ptr_inc(trd_q) : trd_q;
        twr_d  = tpush ? ptr_inc(twr_q) : twr_q;
        tcnt_d = CW'(tcnt_q + CW'(tpush) - CW'(tpop));
        if (mode_chg) begin
            trd_d  = '0;
            twr_d  = '0;
            tcnt_d = '0;
        end
        txv_d  = (tcnt_d != '0);
        // a character written now may already be the new head
        txd_d  = (tpush && twr_q == trd_d) ? pwdata[7:0] : tmem[trd_d];
        thre_d = (tcnt_d == '0);
        temt_d = (tcnt_d == '0) & tsr_empty;
    end

    // transmit storage
    always_ff @(posedge pclk) begin
        if (tpush) begin
            tmem[twr_q] <= pwdata[7:0];
        end
    end

    // events for the interrupt status
    assign ev[uls_pkg::IRQ_THRE] = thre_d & ~thre_q;
    assign ev[uls_pkg::IRQ_LINE] = (push_ok & has_tag(push_ent)) | (push_req & ~push_ok);
    assign ev[uls_pkg::IRQ_RX]   = push_ok;

    ////////////////////////////////////////////////////////////////////////////
    // line_status view and apb answer

    logic [7:0] lsr_v;
    logic       held;     // receive character present
    assign held = (rcnt_q != '0);

    // head tags show only while a character is held
    always_comb begin
        lsr_v                   = 8'h00;
        lsr_v[uls_pkg::LSR_FERR] = ferr_q;
        lsr_v[uls_pkg::LSR_TEMT] = temt_q;
        lsr_v[uls_pkg::LSR_THRE] = thre_q;
        lsr_v[uls_pkg::LSR_BRK]  = held & head.brk;
        lsr_v[uls_pkg::LSR_FE]   = held & head.fe;
        lsr_v[uls_pkg::LSR_PE]   = held & head.pe;
        lsr_v[uls_pkg::LSR_OE]   = oe_q;
        lsr_v[uls_pkg::LSR_DR]   = held;
    end

    // read mux; unmapped reads give zero
    always_comb begin
        unique case (paddr)
            uls_pkg::OFF_LSR:  rd_val = {24'h0, lsr_v};
            uls_pkg::OFF_CTRL: rd_val = {31'h0, fifo_q};
            uls_pkg::OFF_RXD:  rd_val = {24'h0, held ? head.data : 8'h00};
            uls_pkg::OFF_IST:  rd_val = {29'h0, ist_q};
            uls_pkg::OFF_IMSK: rd_val = {29'h0, imsk_q};
            default:           rd_val = 32'h0;
        endcase
    end

    // one wait state: ready rises in the second access cycle
    always_comb begin
        pready_d  = psel & penable & ~pready_q;
        pslverr_d = pready_d & ~mapped;
        prdata_d  = (pready_d && !pwrite) ? rd_val : 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_s1_q   <= 1'b1;
            rxd_s2_q   <= 1'b1;
            brk_cnt_q  <= 32'h0;
            brk_done_q <= 1'b0;
            fifo_q     <= uls_pkg::CTRL_RST;
            ist_q      <= uls_pkg::IST_RST;
            imsk_q     <= uls_pkg::IMSK_RST;
            irq_q      <= 1'b0;
            rrd_q      <= '0;
            rwr_q      <= '0;
            rcnt_q     <= '0;
            ecnt_q     <= '0;
            oe_q       <= 1'b0;
            ferr_q     <= 1'b0;
            trd_q      <= '0;
            twr_q      <= '0;
            tcnt_q     <= '0;
            txv_q      <= 1'b0;
            txd_q      <= 8'h00;
            thre_q     <= uls_pkg::THRE_RST;
            temt_q     <= uls_pkg::TEMT_RST;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            prdata_q   <= 32'h0;
        end else begin
            rxd_s1_q   <= rxd;
            rxd_s2_q   <= rxd_s1_q;
            brk_cnt_q  <= brk_cnt_d;
            brk_done_q <= brk_done_d;
            fifo_q     <= fifo_d;
            ist_q      <= ist_d;
            imsk_q     <= imsk_d;
            irq_q      <= irq_d;
            rrd_q      <= rrd_d;
            rwr_q      <= rwr_d;
            rcnt_q     <= rcnt_d;
            ecnt_q     <= ecnt_d;
            oe_q       <= oe_d;
            ferr_q     <= ferr_d;
            trd_q      <= trd_d;
            twr_q      <= twr_d;
            tcnt_q     <= tcnt_d;
            txv_q      <= txv_d;
            txd_q      <= txd_d;
            thre_q     <= thre_d;
            temt_q     <= temt_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            prdata_q   <= prdata_d;
        end
    end

    // outputs straight from flops
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign tx_valid = txv_q;
    assign tx_data  = txd_q;
    assign irq      = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ferr_on_tag: assert property (fifo_q && push_ok && has_tag(push_ent) && !mode_chg
        |=> ferr_q)
        else $error("error summary not set by tagged character");
    a_ferr_read_clr: assert property (lsr_rd && !push_ok && !mode_chg |=> !ferr_q)
        else $error("error summary survived a status read");
    a_temt_busy: assert property (tcnt_q != '0 |-> !temt_q && !thre_q)
        else $error("empty flag high while transmit character held");
    a_temt_needs: assert property (temt_q |-> thre_q && $past(tsr_empty))
        else $error("transmitter empty without empty shifter");
    a_thre_write: assert property (tpush && !tpop |=> !thre_q)
        else $error("holding empty not cleared by write");
    a_thre_drain: assert property (tpop && tcnt_q == CW'(1) && !tpush |=> thre_q)
        else $error("holding empty not set when drained");
    a_thre_irq: assert property ($rose(thre_q) && imsk_q[uls_pkg::IRQ_THRE] |-> irq_q)
        else $error("holding empty interrupt missing");
    a_brk_fire: assert property (brk_push |-> !rxd_s2_q && brk_cnt_q == 32'(FRAME_CYCLES - 1))
        else $error("break queued without a full low frame");
    a_brk_once: assert property (brk_push |=> !brk_push [*8])
        else $error("second break character for one break");
    a_head_fe: assert property (held && push_ok && !pop && !mode_chg |=> $stable(head.fe))
        else $error("framing flag does not follow head");
    a_dr_level: assert property (push_ok && !pop && !mode_chg |=> lsr_v[uls_pkg::LSR_DR])
        else $error("data ready low with character held");

    c_break: cover property (brk_push ##[1:1000] rxd_rd);
    c_tx_drain: cover property (tpush ##[1:200] $rose(thre_q));
    c_ferr_clear: cover property (ferr_q ##1 lsr_rd ##1 !ferr_q);

endmodule // uls_line_status

`default_nettype wire

/* bench/uls_tx_model.sv */
// transmit shifter model standing behind the line status block
`timescale 1ns/1ps
`default_nettype none

module uls_tx_model #(
    parameter int unsigned SHIFT_CYCLES = 40  // cycles one character occupies the shifter
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // offer from the block
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output var  logic       tx_take,
    output var  logic       tsr_empty,
    // bench control and observation
    input  wire logic       hold,
    output var  logic [7:0] last_char,
    output var  logic [7:0] char_cnt
);
    logic [7:0] busy_q;  // remaining shift cycles

    // accept only while empty and not stalled by the bench
    assign tx_take   = tx_valid & tsr_empty & ~hold;
    assign tsr_empty = (busy_q == 8'h00);

    // shift countdown and capture of each taken character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q    <= 8'h00;
            last_char <= 8'h00;
            char_cnt  <= 8'h00;
        end else if (tx_take) begin
            busy_q    <= SHIFT_CYCLES[7:0];
            last_char <= tx_data;
            char_cnt  <= char_cnt + 8'h01;
        end else if (busy_q != 8'h00) begin
            busy_q <= busy_q - 8'h01;
        end
    end
endmodule // uls_tx_model

`default_nettype wire

/* bench/uls_line_status_tb.sv */
// self-checking bench for the uart line status block
`timescale 1ns/1ps
`default_nettype none

module uls_line_status_tb;
    localparam int unsigned FRAME = 20;     // short break frame for simulation
    localparam int          LIMIT = 20000;  // cycle ceiling for the whole run
    // clock, reset and bus
    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]             paddr, tx_data, last_char, char_cnt, d0, d1, d2;
    logic [31:0]            pwdata, prdata, rdat;
    // receiver, line pin, shifter and interrupt
    logic                   rx_valid, rxd, tx_valid, tx_take, tsr_empty, irq, hold;
    uls_pkg::uls_rx_entry_t rx_entry;
    int                     failures, tests_run, cycles;

    uls_line_status #(.DEPTH(16), .FRAME_CYCLES(FRAME)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_entry(rx_entry), .rxd(rxd), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_take(tx_take), .tsr_empty(tsr_empty), .irq(irq));
    uls_tx_model i_shift (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_take(tx_take), .tsr_empty(tsr_empty), .hold(hold),
        .last_char(last_char), .char_cnt(char_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // expected status from flags {summary,tx empty,holding empty,break,frame,parity,ready}
    function automatic logic [31:0] lsr_exp(input logic [6:0] f);
        lsr_exp = 32'h0;
        lsr_exp[uls_pkg::LSR_FERR] = f[6];
        lsr_exp[uls_pkg::LSR_TEMT] = f[5];
        lsr_exp[uls_pkg::LSR_THRE] = f[4];
        lsr_exp[uls_pkg::LSR_BRK]  = f[3];
        lsr_exp[uls_pkg::LSR_FE]   = f[2];
        lsr_exp[uls_pkg::LSR_PE]   = f[1];
        lsr_exp[uls_pkg::LSR_DR]   = f[0];
    endfunction

    // one comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    // one apb transfer: setup, access held until pready, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // read a register and compare
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask

    // offer one tagged character from the receiver
    task automatic push(input logic b, input logic f, input logic p, input logic [7:0] d);
        rx_valid <= 1'b1;
        rx_entry <= '{brk: b, fe: f, pe: p, data: d};
        @(posedge pclk);
        rx_valid <= 1'b0;
        @(posedge pclk);
    endtask

    // wait until the shifter has taken cnt characters, and optionally gone empty
    task automatic wait_tx(input logic [7:0] cnt, input logic empty);
        while (char_cnt !== cnt || (empty && tsr_empty !== 1'b1)) begin
            @(posedge pclk);
        end
    endtask

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; rx_valid = 1'b0; rx_entry = '0; rxd = 1'b1; hold = 1'b0;
        failures = 0; tests_run = 0; cycles = 0;
        void'($urandom(12));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("status after reset", uls_pkg::OFF_LSR, lsr_exp(7'h30));
        $display("test reset done");
        // queue mode: tags travel with characters and follow the head
        apb(1'b1, uls_pkg::OFF_CTRL, 32'h1);
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        push(1'b0, 1'b0, 1'b0, d0);
        push(1'b0, 1'b1, 1'b0, d1);
        push(1'b0, 1'b0, 1'b1, d2);
        rd_chk("summary set", uls_pkg::OFF_LSR, lsr_exp(7'h71));
        rd_chk("summary cleared by read", uls_pkg::OFF_LSR, lsr_exp(7'h31));
        rd_chk("head char 0", uls_pkg::OFF_RXD, {24'h0, d0});
        rd_chk("framing at head", uls_pkg::OFF_LSR, lsr_exp(7'h35));
        rd_chk("head char 1", uls_pkg::OFF_RXD, {24'h0, d1});
        rd_chk("parity at head", uls_pkg::OFF_LSR, lsr_exp(7'h33));
        rd_chk("head char 2", uls_pkg::OFF_RXD, {24'h0, d2});
        rd_chk("receive drained", uls_pkg::OFF_LSR, lsr_exp(7'h30));
        $display("test receive tags done");
        // long break: exactly one break character while the line stays low
        rxd <= 1'b0;
        repeat (FRAME * 3) @(posedge pclk);
        rd_chk("break queued", uls_pkg::OFF_LSR, lsr_exp(7'h79));
        rd_chk("break char", uls_pkg::OFF_RXD, 32'h0);
        rd_chk("single break", uls_pkg::OFF_LSR, lsr_exp(7'h30));
        rxd <= 1'b1;
        repeat (4) @(posedge pclk);
        $display("test break done");
        // holding register mode: framing error on the one held character
        apb(1'b1, uls_pkg::OFF_CTRL, 32'h0);
        d0 = 8'($urandom);
        push(1'b0, 1'b1, 1'b0, d0);
        rd_chk("framing held", uls_pkg::OFF_LSR, lsr_exp(7'h35));
        // second character while the holding register is full: overrun, head kept
        push(1'b0, 1'b0, 1'b0, d2);
        rd_chk("overrun held", uls_pkg::OFF_LSR, lsr_exp(7'h35) | 32'h2);
        rd_chk("line and receive events", uls_pkg::OFF_IST, 32'h6);
        rd_chk("held char", uls_pkg::OFF_RXD, {24'h0, d0});
        // holding register transmit with the holding-empty interrupt enabled, then masked
        apb(1'b1, uls_pkg::OFF_IST, 32'h7);
        apb(1'b1, uls_pkg::OFF_IMSK, 32'h1);
        hold <= 1'b1;
        apb(1'b1, uls_pkg::OFF_TXD, {24'h0, d1});
        rd_chk("holding loaded", uls_pkg::OFF_LSR, lsr_exp(7'h00));
        chk("irq before transfer", 32'h0, {31'h0, irq});
        hold <= 1'b0;
        wait_tx(8'h01, 1'b0);
        repeat (2) @(posedge pclk);
        rd_chk("shifter busy", uls_pkg::OFF_LSR, lsr_exp(7'h10));
        chk("irq raised", 32'h1, {31'h0, irq});
        chk("shifted char", {24'h0, d1}, {24'h0, last_char});
        wait_tx(8'h01, 1'b1);
        rd_chk("transmitter empty", uls_pkg::OFF_LSR, lsr_exp(7'h30));
        apb(1'b1, uls_pkg::OFF_IST, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, uls_pkg::OFF_IMSK, 32'h0);
        apb(1'b1, uls_pkg::OFF_TXD, {24'h0, d2});
        wait_tx(8'h02, 1'b1);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk("event pending", uls_pkg::OFF_IST, 32'h1);
        $display("test holding transmit done");
        // queue transmit: three random characters behind a stalled shifter
        apb(1'b1, uls_pkg::OFF_CTRL, 32'h1);
        hold <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            d0 = 8'($urandom);
            apb(1'b1, uls_pkg::OFF_TXD, {24'h0, d0});
        end
        rd_chk("queue loaded", uls_pkg::OFF_LSR, lsr_exp(7'h00));
        hold <= 1'b0;
        wait_tx(8'h05, 1'b1);
        chk("last queued char", {24'h0, d0}, {24'h0, last_char});
        rd_chk("queue empty", uls_pkg::OFF_LSR, lsr_exp(7'h30));
        $display("test queue transmit done");
        // unmapped address
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
        $display("test unmapped done");
        close_out();
    end
endmodule // uls_line_status_tb

`default_nettype wire
